// ===== verification/pac_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module pac_ctrl_tb import pac_pkg::*; ;
  logic clk, rst_n, oe_n, alt_on, tog, go, sleep, abv;
  logic [3:0] len;
  logic [14:0] pat;
  pac_raw_t core_raw;
  logic trim_m, pd_m, drv, ready, oor, str, pdr;
  logic [PAC_WORD_W-1:0] word;
  logic [15:0] n_good;
  int miscompares = 0;
  int n_compared = 0;
  int cyc = 0;

  // ----------------------------------------------------------------
  // clock, stimulus, instances
  // ----------------------------------------------------------------
  // one steady clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // toggling decisions give each trim slot 124 or 125 ones over its 249 counted cycles
  assign core_raw = '{dec: alt_on ? {15{tog}} : pat, below: 1'b0,
    above: abv};
  always @(posedge clk) tog <= ~tog;

  pac_ctrl pac_ctrl_inst (.clk(clk), .rst_n(rst_n),
    .self_trim_request(str), .power_down_request(pdr),
    .output_drive_enable_n(oe_n), .core_raw(core_raw),
    .core_trim_mode(trim_m), .core_power_down(pd_m), .sample_word(word),
    .out_of_range_flag(oor), .sample_drive_en(drv), .ready(ready));
  pac_host_model pac_host_model_inst (.clk(clk), .rst_n(rst_n), .go(go),
    .trim_len(len), .sleep(sleep), .ready(ready), .sample_word(word),
    .self_trim_request(str), .power_down_request(pdr), .n_good(n_good));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic until_ready(input logic v, input int lim, output int n);
    n = 0;
    while (ready !== v && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power_on;
    int n;
    tick(2);
    `CHK(ready, 1'b0)
    `CHK(trim_m, 1'b1)
    until_ready(1'b1, 4100, n);
    `CHK(n > 3990, 1'b1)
  endtask

  task automatic t_drive;
    for (int i = 0; i < 2; i++) begin
      oe_n <= i[0];
      tick(1);
      `CHK(drv, ~i[0])
    end
  endtask

  task automatic t_stream;
    logic [14:0] p [2] = '{15'h7fff, 15'h0000};
    logic [11:0] e [4] = '{12'h7ff, 12'hfff, 12'h800, 12'h000};
    alt_on <= 1'b0;
    pat <= 15'h0000;
    tick(20);
    `CHK(word, 12'h000)
    for (int i = 0; i < 2; i++) begin
      pat <= p[i];
      tick(14);
      `CHK(word, e[2*i])
      tick(1);
      `CHK(word, e[2*i+1])
    end
    abv <= 1'b1;
    tick(20);
    `CHK(oor, 1'b1)
    abv <= 1'b0;
    tick(20);
    `CHK(oor, 1'b0)
    `CHK(n_good > 16'h0000, 1'b1)
    alt_on <= 1'b1;
  endtask

  task automatic t_trim;
    int n;
    len <= 4'h2;
    go <= ~go;
    tick(8);
    `CHK(ready, 1'b1)
    len <= 4'h3;
    go <= ~go;
    while (str !== 1'b1) tick(1);
    until_ready(1'b0, 6, n);
    `CHK(n <= 3, 1'b1)
    `CHK(trim_m, 1'b1)
    n = 1;
    while (ready !== 1'b1 && n < 5000) begin
      if (n == 100) go <= ~go;
      tick(1);
      n++;
    end
    `CHK(n, 4001)
  endtask

  task automatic t_sleep;
    int n;
    sleep <= 1'b1;
    until_ready(1'b0, 6, n);
    `CHK(n <= 3, 1'b1)
    tick(5);
    `CHK(pd_m, 1'b1)
    `CHK(word, 12'h000)
    sleep <= 1'b0;
    until_ready(1'b1, 4100, n);
    `CHK(n >= 3995 && n <= 4010, 1'b1)
    // re-trim asked for inside the wake interval
    sleep <= 1'b1;
    tick(4);
    sleep <= 1'b0;
    tick(10);
    `CHK(pd_m, 1'b0)
    `CHK(ready, 1'b0)
    go <= ~go;
    tick(5);
    `CHK(trim_m, 1'b1)
  endtask

  initial begin
    rst_n = 1'b0;
    oe_n = 1'b0;
    alt_on = 1'b1;
    tog = 1'b0;
    go = 1'b0;
    sleep = 1'b0;
    abv = 1'b0;
    len = 4'h3;
    pat = 15'h0000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_power_on();
    t_drive();
    t_stream();
    t_trim();
    t_sleep();
    end_sim();
  end
endmodule

// ===== verification/pac_host_model.sv
`timescale 1ns/1ps
module pac_host_model import pac_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench commands
  input wire logic go,
  input wire logic [3:0] trim_len,
  input wire logic sleep,
  // converter side
  input wire logic ready,
  input wire logic [PAC_WORD_W-1:0] sample_word,
  output logic self_trim_request,
  output logic power_down_request,
  output logic [15:0] n_good
);
  logic go_q;
  logic [3:0] left_q;
  logic [4:0] skip_q;
  logic [PAC_WORD_W-1:0] last_q;

  // ----------------------------------------------------------------
  // requests
  // ----------------------------------------------------------------
  // hold trim level
  // a toggle of go starts a request of trim_len cycles; short lengths
  // let the bench try a request that must be refused
  always_ff @(posedge clk) begin
    go_q <= go;
    if (!rst_n) begin
      left_q <= 4'h0;
    end else if (go != go_q) begin
      left_q <= trim_len;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  assign self_trim_request = left_q != 4'h0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_down_request <= 1'b0;
    end else begin
      power_down_request <= sleep;
    end
  end

  // ----------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------
  // discard stale words
  always_ff @(posedge clk) begin
    if (!rst_n || !ready) begin
      skip_q <= 5'(PAC_PIPE_LAT);
    end else if (skip_q != 5'h00) begin
      skip_q <= skip_q - 5'h01;
    end else begin
      last_q <= sample_word;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      n_good <= 16'h0000;
    end else if (ready && skip_q == 5'h00) begin
      n_good <= n_good + 16'h0001;
    end
  end
endmodule

// ===== verilog/pac_coef_ram.sv
`timescale 1ns/1ps
module pac_coef_ram import pac_pkg::*; #(
  parameter int N = PAC_STAGES,
  parameter int W = PAC_COEF_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // trim write port
  input wire logic wr_en,
  input wire logic [PAC_IDX_W-1:0] wr_idx,
  input wire logic [W-1:0] wr_data,
  // all coefficients, registered
  output logic [N*W-1:0] rd_all
);

  // every word is read each cycle, so the store is a register file
  for (genvar i = 0; i < N; i++) begin : g_word
    logic [W-1:0] mem_q;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        mem_q <= W'(pac_nominal(i));
      end else if (wr_en && wr_idx == PAC_IDX_W'(i)) begin
        mem_q <= wr_data;
      end
    end
    assign rd_all[i*W +: W] = mem_q;
  end

endmodule

// ===== verilog/pac_correct.sv
`timescale 1ns/1ps
module pac_correct import pac_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  // raw decisions and coefficients
  input pac_raw_t raw,
  input wire logic [PAC_STAGES*PAC_COEF_W-1:0] coef,
  // corrected result
  output pac_sample_t sample
);

  localparam int DLY = PAC_STAGES - 1;

  logic [PAC_STAGES-1:0] aligned;
  logic [DLY-1:0] below_q;
  logic [DLY-1:0] above_q;
  logic [PAC_SUM_W-1:0] sum_d;
  pac_sample_t sample_q;

  // ----------------------------------------------------------------
  // deskew: stage k decides k cycles after the sample was taken
  // ----------------------------------------------------------------
  for (genvar k = 0; k < PAC_STAGES; k++) begin : g_skew
    localparam int D = DLY - k;
    if (D > 0) begin : g_dly
      logic [D-1:0] sr_q;
      always_ff @(posedge clk) begin
        if (!rst_n || flush) begin
          sr_q <= '0;
        end else begin
          // cast keeps the low D bits, so a single flop needs no case
          sr_q <= D'({sr_q, raw.dec[k]});
        end
      end
      assign aligned[k] = sr_q[D-1];
    end else begin : g_now
      assign aligned[k] = raw.dec[k];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      below_q <= '0;
      above_q <= '0;
    end else begin
      below_q <= {below_q[DLY-2:0], raw.below};
      above_q <= {above_q[DLY-2:0], raw.above};
    end
  end

  // ----------------------------------------------------------------
  // weighted sum with trimmed coefficients
  // ----------------------------------------------------------------
  always_comb begin
    sum_d = '0;
    for (int k = 0; k < PAC_STAGES; k++) begin
      if (aligned[k]) begin
        sum_d = sum_d + PAC_SUM_W'(coef[k*PAC_COEF_W +: PAC_COEF_W]);
      end
    end
  end

  // word leaves a fixed 15 edges after stage 0
  // clamp keeps a trimmed overshoot from wrapping to a low code
  always_ff @(posedge clk) begin
    if (!rst_n || flush) begin
      sample_q <= '0;
    end else if (|sum_d[PAC_SUM_W-1:PAC_WORD_W+PAC_SUM_SHIFT]) begin
      sample_q.word <= '1;
      sample_q.oor <= 1'b1;
    end else begin
      sample_q.word <= sum_d[PAC_WORD_W+PAC_SUM_SHIFT-1:PAC_SUM_SHIFT];
      sample_q.oor <= below_q[DLY-1] | above_q[DLY-1];
    end
  end

  assign sample = sample_q;

endmodule

// ===== verilog/pac_ctrl.sv
`timescale 1ns/1ps
// Behaviour
// - a new sample word appears on the outputs every clock while running.
// - each result leaves a fixed number of cycles after its sample.
// - fifteen stages each feed one decision bit to correction.
// - correction weighs decisions by stored coefficients into a 12-bit code.
// - self-trim runs after reset and again on host request.
// - trim measures each stage and writes its coefficient to the store.
// - self-trim lasts 4000 cycles before conversion resumes; a sleep request during trim ends it early and wake then leads to running.
// - output words during trim are meaningless and must be ignored.
// - drive enable low drives the data outputs, high releases them.
// - power-down request high holds the core idle, no conversions.
// - after power-down falls, normal operation resumes within exit interval.
// - pipeline contents are lost over power-down; early results invalid.
// - ready is high only when converting; low in trim and power-down.
// - ready falls within three cycles of a trim or sleep request.
// - power-down exit interval is 4000 cycles.
// - sample word is straight unsigned binary.
// - out-of-range flag is high when the input is outside the range.
module pac_ctrl import pac_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host control levels
  input wire logic self_trim_request,
  input wire logic power_down_request,
  input wire logic output_drive_enable_n,
  // analog core
  input pac_raw_t core_raw,
  output logic core_trim_mode,
  output logic core_power_down,
  // sample output
  output logic [PAC_WORD_W-1:0] sample_word,
  output logic out_of_range_flag,
  output logic sample_drive_en,
  output logic ready
);

  pac_state_t state_q;
  logic [1:0] req_cnt_q;
  logic trim_go;
  logic [PAC_CNT_W-1:0] trim_cnt_q;
  logic [PAC_CNT_W-1:0] exit_cnt_q;
  logic [7:0] slot_cnt_q;
  logic [PAC_IDX_W-1:0] slot_idx_q;
  logic [7:0] ones_q;
  logic coef_wr;
  logic [PAC_COEF_W:0] coef_calc;
  logic [PAC_COEF_W-1:0] coef_val;
  logic [PAC_STAGES*PAC_COEF_W-1:0] coef_all;
  pac_sample_t sample;
  logic trimming;
  logic sleeping;

  assign trimming = (state_q == PAC_TRIM);
  assign sleeping = (state_q == PAC_SLEEP);

  // ----------------------------------------------------------------
  // trim request qualification
  // ----------------------------------------------------------------
  // count consecutive high samples
  always_ff @(posedge clk) begin
    if (!rst_n || !self_trim_request) begin
      req_cnt_q <= '0;
    end else if (req_cnt_q != 2'(PAC_REQ_CYCLES)) begin
      req_cnt_q <= req_cnt_q + 2'h1;
    end
  end

  // a request held longer than three cycles starts only one trim:
  // the count parks past the threshold until the level drops
  assign trim_go = self_trim_request &&
                   req_cnt_q == 2'(PAC_REQ_CYCLES - 1);

  // ----------------------------------------------------------------
  // operating state
  // ----------------------------------------------------------------
  // reset lands straight in trim
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= PAC_TRIM;
    end else begin
      case (state_q)
        PAC_RUN: begin
          // sleep wins over a trim request
          if (power_down_request) begin
            state_q <= PAC_SLEEP;
          end else if (trim_go) begin
            state_q <= PAC_TRIM;
          end
        end
        PAC_TRIM: begin
          // trim requests ignored here, only the count or a sleep request ends trim
          if (power_down_request) begin
            state_q <= PAC_SLEEP;
          end else if (trim_cnt_q == PAC_CNT_W'(PAC_TRIM_CYCLES - 1)) begin
            state_q <= PAC_RUN;
          end
        end
        PAC_SLEEP: begin
          if (!power_down_request) begin
            state_q <= PAC_WAKE;
          end
        end
        PAC_WAKE: begin
          // a wake interval not cut short by a sleep or trim request ends in normal running
          if (power_down_request) begin
            state_q <= PAC_SLEEP;
          end else if (trim_go) begin
            state_q <= PAC_TRIM;
          end else if (exit_cnt_q == PAC_CNT_W'(PAC_EXIT_CYCLES - 1)) begin
            state_q <= PAC_RUN;
          end
        end
        default: begin
          state_q <= PAC_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interval counters
  // ----------------------------------------------------------------
  // trim length
  always_ff @(posedge clk) begin
    if (!rst_n || !trimming) begin
      trim_cnt_q <= '0;
    end else begin
      trim_cnt_q <= trim_cnt_q + PAC_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_q != PAC_WAKE) begin
      exit_cnt_q <= '0;
    end else begin
      exit_cnt_q <= exit_cnt_q + PAC_CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // coefficient measurement
  // ----------------------------------------------------------------
  // one slot per stage; the sixteenth slot is idle settling time
  always_ff @(posedge clk) begin
    if (!rst_n || !trimming) begin
      slot_cnt_q <= '0;
      slot_idx_q <= '0;
    end else if (slot_cnt_q == 8'(PAC_SLOT_CYCLES - 1)) begin
      slot_cnt_q <= '0;
      slot_idx_q <= slot_idx_q + PAC_IDX_W'(1);
    end else begin
      slot_cnt_q <= slot_cnt_q + 8'h01;
    end
  end

  // stage bias seen as ones density in measuring mode
  always_ff @(posedge clk) begin
    if (!rst_n || !trimming || slot_cnt_q == 8'(PAC_SLOT_CYCLES - 1)) begin
      ones_q <= '0;
    end else if (slot_idx_q < PAC_IDX_W'(PAC_STAGES)) begin
      ones_q <= ones_q + 8'(core_raw.dec[slot_idx_q]);
    end
  end

  assign coef_calc = {1'b0, pac_nominal(int'(slot_idx_q))} +
                     {9'h000, ones_q} - PAC_SLOT_HALF;
  // a negative trimmed weight is floored at zero
  assign coef_val = coef_calc[PAC_COEF_W] ? '0 :
                    coef_calc[PAC_COEF_W-1:0];
  assign coef_wr = trimming &&
                   slot_cnt_q == 8'(PAC_SLOT_CYCLES - 1) &&
                   slot_idx_q < PAC_IDX_W'(PAC_STAGES);

  pac_coef_ram #(
    .N(PAC_STAGES),
    .W(PAC_COEF_W)
  ) u_ram (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(coef_wr),
    .wr_idx(slot_idx_q),
    .wr_data(coef_val),
    .rd_all(coef_all)
  );

  // ----------------------------------------------------------------
  // result path
  // ----------------------------------------------------------------
  // deskew fifteen decisions and weigh them
  pac_correct u_corr (
    .clk(clk),
    .rst_n(rst_n),
    .flush(sleeping),
    .raw(core_raw),
    .coef(coef_all),
    .sample(sample)
  );

  // trim words pass unmarked; ready low flags them
  // registered unsigned word, one per clock
  assign sample_word = sample.word;
  // range flag travels with its word
  assign out_of_range_flag = sample.oor;
  // driver enable follows the active-low pin
  assign sample_drive_en = !output_drive_enable_n;

  // ----------------------------------------------------------------
  // status to core and host
  // ----------------------------------------------------------------
  // core held in low power
  assign core_power_down = sleeping;
  assign core_trim_mode = trimming;
  assign ready = (state_q == PAC_RUN);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  localparam int FALL_MAX = PAC_READY_FALL;

  sequence s_req3;
    !self_trim_request ##1
      (ready && self_trim_request && !power_down_request)[*3];
  endsequence

  sequence s_sleep_on;
    ready ##1 (power_down_request && ready);
  endsequence

  property p_req_start;
    s_req3 |=> trimming && !ready;
  endproperty
  a_req_start: assert property (p_req_start)
    else $error("held trim request did not start trim");

  property p_ready_fall;
    $rose(self_trim_request) && !power_down_request
      ##0 self_trim_request[*3] |-> ##[0:FALL_MAX] !ready;
  endproperty
  a_ready_fall: assert property (p_ready_fall)
    else $error("ready did not fall after trim request");

  property p_sleep_fall;
    s_sleep_on |-> ##[0:FALL_MAX] !ready;
  endproperty
  a_sleep_fall: assert property (p_sleep_fall)
    else $error("ready did not fall after sleep request");

  property p_trim_len;
    $fell(trimming) && !$past(power_down_request) |->
      $past(trim_cnt_q) == PAC_CNT_W'(PAC_TRIM_CYCLES - 1) && ready;
  endproperty
  a_trim_len: assert property (p_trim_len)
    else $error("trim did not last its full length");

  property p_no_shorten;
    trimming && self_trim_request && !power_down_request &&
      trim_cnt_q < PAC_CNT_W'(PAC_TRIM_CYCLES - 1) |=> trimming;
  endproperty
  a_no_shorten: assert property (p_no_shorten)
    else $error("trim request shortened a running trim");

  property p_wake_len;
    $fell(state_q == PAC_WAKE) && state_q == PAC_RUN |->
      $past(exit_cnt_q) == PAC_CNT_W'(PAC_EXIT_CYCLES - 1);
  endproperty
  a_wake_len: assert property (p_wake_len)
    else $error("wake interval wrong length");

  property p_sleep_hold;
    power_down_request[*2] |-> core_power_down && !ready;
  endproperty
  a_sleep_hold: assert property (p_sleep_hold)
    else $error("core not held in power-down");

  property p_ready_state;
    ready |-> !core_trim_mode && !core_power_down;
  endproperty
  a_ready_state: assert property (p_ready_state)
    else $error("ready high during trim or power-down");

  property p_flush;
    sleeping |=> sample_word == '0 && !out_of_range_flag;
  endproperty
  a_flush: assert property (p_flush)
    else $error("pipeline not cleared in power-down");

  property p_after_reset;
    $rose(rst_n) |-> trimming;
  endproperty
  a_after_reset: assert property (@(posedge clk) p_after_reset)
    else $error("trim did not start after reset");

  property p_coef_writes;
    $rose(trimming) ##1 (trimming && !power_down_request)[*8]
      |-> !coef_wr;
  endproperty
  a_coef_writes: assert property (p_coef_writes)
    else $error("coefficient written before a slot finished");

endmodule

// ===== verilog/pac_pkg.sv
package pac_pkg;

  // ----------------------------------------------------------------
  // core geometry
  // ----------------------------------------------------------------
  localparam int PAC_STAGES = 15;
  localparam int PAC_WORD_W = 12;
  localparam int PAC_COEF_W = 16;
  localparam int PAC_SUM_W = 20;
  localparam int PAC_SUM_SHIFT = 3;
  localparam int PAC_IDX_W = 4;
  localparam int PAC_PIPE_LAT = 15;

  // ----------------------------------------------------------------
  // timing counts, in convert clock cycles
  // ----------------------------------------------------------------
  localparam int PAC_REQ_CYCLES = 3;
  localparam int PAC_READY_FALL = 3;
  localparam int PAC_TRIM_CYCLES = 4000;
  localparam int PAC_EXIT_CYCLES = 4000;
  localparam int PAC_SLOT_CYCLES = 250;
  localparam int PAC_CNT_W = 12;
  localparam logic [PAC_COEF_W:0] PAC_SLOT_HALF = 17'h0007d;

  // ----------------------------------------------------------------
  // carriers and states
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [PAC_STAGES-1:0] dec;
    logic below;
    logic above;
  } pac_raw_t;

  typedef struct packed {
    logic [PAC_WORD_W-1:0] word;
    logic oor;
  } pac_sample_t;

  typedef enum logic [1:0] {PAC_RUN, PAC_TRIM, PAC_SLEEP, PAC_WAKE}
    pac_state_t;

  // untrimmed binary weight of a stage decision
  function automatic logic [PAC_COEF_W-1:0] pac_nominal(input int k);
    pac_nominal = 16'h0001 << (PAC_STAGES - 1 - k);
  endfunction

endpackage
